// ===== core/flash_ctrl.sv
// host controller driving a parallel word flash through its pins
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module flash_ctrl (
    input  wire logic        clk_i,      // 25 MHz clock
    input  wire logic        arst_n_i,   // async reset, active low
    input  wire logic [3:0]  addr_i,     // register address
    input  wire logic [15:0] wdata_i,    // register write data
    input  wire logic        wr_i,       // write strobe
    input  wire logic        rd_i,       // read strobe
    output logic      [15:0] rdata_o,    // read data, cycle after rd_i
    output logic      [15:0] fl_addr_o,  // flash address pins
    output logic      [15:0] fl_dq_o,    // flash data out
    output logic             fl_dq_oe_o, // flash data drive enable
    input  wire logic [15:0] fl_dq_i,    // flash data in
    output logic             fl_ce_n_o,  // chip select, active low
    output logic             fl_oe_n_o,  // output gate, active low
    output logic             fl_we_n_o   // write strobe, active low
);
    import flash_ctrl_pkg::*;

    // ****************************************
    // sequence table
    // ****************************************
    localparam logic [2:0] STROBE_W = 3'(`STROBE_CYC + 1);
    localparam logic [2:0] READ_W   = 3'd2; // 120 ns covers 45 ns access

    state_t      state_q;
    op_t         op_q;
    logic [2:0]  step_q;
    logic [2:0]  cnt_q;
    logic [15:0] tgt_addr_q;
    logic [15:0] tgt_data_q;
    logic [15:0] rdbuf_q;
    logic [15:0] last_q;
    logic [15:0] polls_q;
    logic        busy_q;
    logic        done_q;
    logic        fail_q;
    logic        poll_q;
    logic        fl_oe_q;
    logic        last_tgl_q;

    logic [2:0]  nsteps;
    logic [15:0] cyc_addr;
    logic [15:0] cyc_data;
    logic        needs_poll;

    // unlock prefix, then code, except short ID exit (single F0 to 0000); program and lockout-style erase have extras
    always_comb
    begin
        nsteps   = 3'd3;
        cyc_addr = `ADDR_UNLOCK1;
        cyc_data = `DAT_UNLOCK1;
        case (op_q)
            OP_PROGRAM:       nsteps = 3'd4;
            OP_CHIP_ERASE,
            OP_MAIN_ERASE,
            OP_LOCKOUT:       nsteps = 3'd6;
            OP_ID_EXIT_SHORT: nsteps = 3'd1;
            default:          nsteps = 3'd3;
        endcase
        case (step_q)
            3'd0:
            begin
                cyc_addr = `ADDR_UNLOCK1;
                cyc_data = `DAT_UNLOCK1;
            end
            3'd1, 3'd4:
            begin
                cyc_addr = `ADDR_UNLOCK2;
                cyc_data = `DAT_UNLOCK2;
            end
            3'd2:
            begin
                cyc_addr = `ADDR_UNLOCK1;
                case (op_q)
                    OP_PROGRAM:  cyc_data = `DAT_PROGRAM;
                    OP_ID_ENTRY: cyc_data = `DAT_ID_ENTRY;
                    OP_ID_EXIT:  cyc_data = `DAT_ID_EXIT;
                    default:     cyc_data = `DAT_ERASE_PRE;
                endcase
            end
            3'd3:
            begin
                cyc_addr = (op_q == OP_PROGRAM) ? tgt_addr_q : `ADDR_UNLOCK1;
                cyc_data = (op_q == OP_PROGRAM) ? tgt_data_q : `DAT_UNLOCK1;
            end
            3'd5:
            begin
                cyc_addr = `ADDR_UNLOCK1;
                case (op_q)
                    OP_CHIP_ERASE: cyc_data = `DAT_CHIP_ERASE;
                    OP_MAIN_ERASE: cyc_data = `DAT_MAIN_ERASE;
                    default:       cyc_data = `DAT_LOCKOUT;
                endcase
            end
            default: ;
        endcase
        if (op_q == OP_ID_EXIT_SHORT)
        begin
            cyc_addr = 16'h0000;
            cyc_data = `DAT_ID_EXIT;
        end
        needs_poll  = (op_q == OP_PROGRAM) || (op_q == OP_CHIP_ERASE) ||
                      (op_q == OP_MAIN_ERASE) || (op_q == OP_LOCKOUT);
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_q    <= ST_IDLE;
            step_q     <= 3'd0;
            cnt_q      <= 3'd0;
            fl_ce_n_o  <= 1'b1;
            fl_oe_n_o  <= 1'b1;
            fl_we_n_o  <= 1'b1;
            fl_addr_o  <= 16'h0000;
            fl_dq_o    <= 16'h0000;
            rdbuf_q    <= 16'h0000;
            last_q     <= 16'h0000;
            polls_q    <= 16'h0000;
            busy_q     <= 1'b0;
            done_q     <= 1'b0;
            fail_q     <= 1'b0;
            poll_q     <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (wr_i && addr_i == `REG_CMD && op_t'(wdata_i[3:0]) != OP_NONE)
                    begin
                        busy_q  <= 1'b1;
                        done_q  <= 1'b0;
                        fail_q  <= 1'b0;
                        step_q  <= 3'd0;
                        polls_q <= 16'h0000;
                        state_q <= (op_t'(wdata_i[3:0]) == OP_READ ||
                                    op_t'(wdata_i[3:0]) == OP_LOCK_QUERY) ? ST_RSETUP : ST_SETUP;
                    end
                end
                // write cycle: gate high first so no program is inhibited
                ST_SETUP:
                begin
                    fl_oe_n_o  <= 1'b1;
                    fl_addr_o  <= cyc_addr;
                    fl_dq_o    <= cyc_data;
                    fl_ce_n_o  <= 1'b0;
                    cnt_q      <= 3'd0;
                    state_q    <= ST_STROBE;
                end
                ST_STROBE:
                begin
                    fl_we_n_o <= 1'b0;
                    cnt_q     <= cnt_q + 3'd1;
                    if (cnt_q == STROBE_W)
                    begin
                        fl_we_n_o <= 1'b1;
                        state_q   <= ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    fl_ce_n_o <= 1'b1;
                    state_q   <= ST_NEXT;
                end
                ST_NEXT:
                begin
                    if (step_q + 3'd1 < nsteps)
                    begin
                        step_q  <= step_q + 3'd1;
                        state_q <= ST_SETUP;
                    end
                    else if (needs_poll)
                    begin
                        last_q  <= (op_q == OP_PROGRAM) ? tgt_addr_q : 16'h1FFF;
                        poll_q  <= 1'b1;
                        state_q <= ST_RSETUP;
                    end
                    else
                    begin
                        busy_q  <= 1'b0;
                        done_q  <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                // read cycle: strobe stays high while gate drives
                ST_RSETUP:
                begin
                    fl_we_n_o <= 1'b1;
                    fl_addr_o <= poll_q ? last_q :
                                 (op_q == OP_LOCK_QUERY) ? `ADDR_LOCKQ : tgt_addr_q;
                    fl_ce_n_o <= 1'b0;
                    fl_oe_n_o <= 1'b0;
                    cnt_q     <= 3'd0;
                    state_q   <= ST_RSAMPLE;
                end
                ST_RSAMPLE:
                begin
                    cnt_q <= cnt_q + 3'd1;
                    if (cnt_q == READ_W)
                    begin
                        rdbuf_q   <= fl_dq_i;
                        fl_ce_n_o <= 1'b1;
                        fl_oe_n_o <= 1'b1;
                        state_q   <= ST_RDONE;
                    end
                end
                ST_RDONE:
                begin
                    if (!poll_q)
                    begin
                        busy_q  <= 1'b0;
                        done_q  <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                    // program done when bit 7 is true data
                    else if (op_q == OP_PROGRAM &&
                             rdbuf_q[`POLL_BIT] == tgt_data_q[`POLL_BIT])
                    begin
                        poll_q  <= 1'b0;
                        busy_q  <= 1'b0;
                        done_q  <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                    else
                    begin
                        state_q <= ST_POLL_WAIT;
                    end
                end
                // erase done when bit 6 stops toggling between reads
                ST_POLL_WAIT:
                begin
                    polls_q <= polls_q + 16'h0001;
                    if (op_q != OP_PROGRAM && polls_q != 16'h0000 &&
                        rdbuf_q[`TOGGLE_BIT] == last_tgl_q)
                    begin
                        poll_q  <= 1'b0;
                        busy_q  <= 1'b0;
                        done_q  <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                    else if (polls_q == `POLL_LIMIT)
                    begin
                        poll_q  <= 1'b0;
                        busy_q  <= 1'b0;
                        fail_q  <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                    else
                    begin
                        state_q <= ST_RSETUP;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // data pin drive and toggle history
    // ****************************************
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            fl_oe_q <= 1'b0;
        else if (state_q == ST_SETUP)
            fl_oe_q <= 1'b1;
        else if (state_q == ST_HOLD || state_q == ST_IDLE)
            fl_oe_q <= 1'b0;
    end
    assign fl_dq_oe_o = fl_oe_q;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            last_tgl_q <= 1'b0;
        else if (state_q == ST_POLL_WAIT)
            last_tgl_q <= rdbuf_q[`TOGGLE_BIT];
    end

    // ****************************************
    // register port; commands ignored while busy
    // ****************************************
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            op_q       <= OP_NONE;
            tgt_addr_q <= 16'h0000;
            tgt_data_q <= 16'hFFFF;
        end
        else if (wr_i && !busy_q)
        begin
            case (addr_i)
                `REG_CMD:   op_q       <= op_t'(wdata_i[3:0]);
                `REG_ADDR:  tgt_addr_q <= wdata_i;
                `REG_WDATA: tgt_data_q <= wdata_i;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rdata_o <= 16'h0000;
        else if (rd_i)
        begin
            case (addr_i)
                `REG_CMD:    rdata_o <= {12'h000, op_q};
                `REG_ADDR:   rdata_o <= tgt_addr_q;
                `REG_WDATA:  rdata_o <= tgt_data_q;
                `REG_STATUS: rdata_o <= {12'h000, rdbuf_q[`LOCK_BIT], fail_q, done_q, busy_q};
                `REG_RDATA:  rdata_o <= rdbuf_q;
                `REG_POLLS:  rdata_o <= polls_q;
                default:     rdata_o <= 16'h0000;
            endcase
        end
        else
            rdata_o <= 16'h0000;
    end
endmodule // flash_ctrl

// ===== shared/flash_ctrl_map.svh
// constants of the flash controller: register offsets, command codes, timing
// Contract
// - Main erase is six cycles ending 30H written to 555H.
// - Word program needs a four-cycle command sequence.
// - Lockout is enabled only by its own six-cycle sequence.
// - Host issues identification exit after querying.
// - Only data bits 7:0 and address bits 11:0 are decoded.
// - Commands open AA to 555, 55 to AAA, then code to 555.
// - Identification left by prefixed exit or single F0 write.
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH
// ****************************************
// host-side register offsets
// ****************************************
`define REG_CMD        4'h0
`define REG_ADDR       4'h1
`define REG_WDATA      4'h2
`define REG_STATUS     4'h3
`define REG_RDATA      4'h4
`define REG_POLLS      4'h5
// ****************************************
// command codes and addresses
// ****************************************
`define ADDR_UNLOCK1   16'h0555
`define ADDR_UNLOCK2   16'h0AAA
`define ADDR_LOCKQ     16'h0002
`define DAT_UNLOCK1    16'h00AA
`define DAT_UNLOCK2    16'h0055
`define DAT_PROGRAM    16'h00A0
`define DAT_ERASE_PRE  16'h0080
`define DAT_CHIP_ERASE 16'h0010
`define DAT_MAIN_ERASE 16'h0030
`define DAT_LOCKOUT    16'h0040
`define DAT_ID_ENTRY   16'h0090
`define DAT_ID_EXIT    16'h00F0
`define POLL_BIT       7
`define TOGGLE_BIT     6
`define LOCK_BIT       0
// ****************************************
// timing: 25 MHz clock, 40 ns
// ****************************************
`define CLK_PERIOD_NS  40
`define STROBE_MIN_NS  15
`define STROBE_CYC     ((`STROBE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WORD_PROGRAM_TIME_NS 10000
`define POLL_LIMIT     16'hFFFF
`endif

// ===== shared/flash_ctrl_pkg.sv
// types of the flash controller
package flash_ctrl_pkg;
    typedef enum logic [3:0] {
        OP_NONE, OP_READ, OP_PROGRAM, OP_CHIP_ERASE, OP_MAIN_ERASE,
        OP_LOCKOUT, OP_ID_ENTRY, OP_ID_EXIT, OP_ID_EXIT_SHORT, OP_LOCK_QUERY
    } op_t;
    typedef enum {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_NEXT,
        ST_RSETUP, ST_RSAMPLE, ST_RDONE, ST_POLL_WAIT
    } state_t;
endpackage

// ===== verif/flash_ctrl_chk.sv
// concurrent checks on the flash controller pins
`timescale 1ns/1ps
module flash_ctrl_chk (
    input wire logic        clk_i,      // clock
    input wire logic        arst_n_i,   // reset
    input wire logic [3:0]  addr_i,     // reg address
    input wire logic [15:0] wdata_i,    // reg data
    input wire logic        wr_i,       // reg write
    input wire logic        rd_i,       // reg read
    input wire logic [15:0] rdata_o,    // reg read data
    input wire logic [15:0] fl_addr_o,  // flash address
    input wire logic [15:0] fl_dq_o,    // flash data out
    input wire logic        fl_dq_oe_o, // data drive
    input wire logic [15:0] fl_dq_i,    // flash data in
    input wire logic        fl_ce_n_o,  // select
    input wire logic        fl_oe_n_o,  // gate
    input wire logic        fl_we_n_o   // strobe
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    sequence s_we_fall;
        $fell(fl_we_n_o);
    endsequence
    sequence s_we_rise;
        $rose(fl_we_n_o);
    endsequence
    a_write_inhibit: assert property (!fl_we_n_o |-> !fl_ce_n_o && fl_oe_n_o && fl_dq_oe_o)
        else $error("strobe low with bad select, gate or drive");
    a_no_contention: assert property (!fl_oe_n_o |-> !fl_dq_oe_o) else $error("data driven under gate");
    a_read_select: assert property ($fell(fl_oe_n_o) |-> !fl_ce_n_o && fl_we_n_o)
        else $error("read without select");
    a_strobe_width: assert property (s_we_fall |=> !fl_we_n_o) else $error("strobe pulse too short");
    a_strobe_bound: assert property (s_we_fall |-> ##[1:8] s_we_rise) else $error("strobe stuck low");
    a_write_hold: assert property (!fl_we_n_o && $past(!fl_we_n_o) |-> $stable(fl_dq_o) && $stable(fl_addr_o))
        else $error("address or data moved under strobe");
    a_unlock_addr: assert property (s_we_rise ##0 fl_dq_o[7:0] == 8'h55 |-> fl_addr_o[11:0] == 12'hAAA)
        else $error("second unlock not at AAA");
    a_code_addr: assert property (s_we_rise ##0 fl_dq_o[7:0] inside {8'hAA, 8'h80, 8'h90, 8'h10, 8'h30, 8'h40}
        |-> fl_addr_o[11:0] == 12'h555) else $error("command code not at 555");
endmodule // flash_ctrl_chk

// ===== verif/flash_dev_model.sv
// behavioural model of the parallel word flash
`timescale 1ns/1ps
module flash_dev_model #(
    parameter int          PROG_NS  = 10000,    // word program time
    parameter int          ERASE_NS = 20000,    // shortened erase time
    parameter logic [15:0] MAKER_ID = 16'h00A5, // arbitrary value
    parameter logic [15:0] PART_ID  = 16'h005A  // arbitrary value
) (
    input  wire logic [15:0] addr_i, // address pins
    input  wire logic [15:0] dq_i,   // wire data
    input  wire logic        ce_n_i, // select
    input  wire logic        oe_n_i, // gate
    input  wire logic        we_n_i, // strobe
    output logic      [15:0] dq_o    // device drive
);
    logic [15:0] mem_q [int];
    logic [15:0] a_q, pd_q, rv, last_q = 16'h0;
    logic        busy_q = 1'b0, tog_q = 1'b0, id_q = 1'b0, lock_q = 1'b0, act_q = 1'b0;
    int          step_q = 0;
    realtime     t0;
    always @*
    begin
        rv = mem_q.exists(int'(addr_i)) ? mem_q[int'(addr_i)] : 16'hFFFF;
        if (id_q) rv = (addr_i == 16'h0002) ? {15'h0, lock_q} : (addr_i[0] ? PART_ID : MAKER_ID);
        if (busy_q) rv = {pd_q[15:8], ~pd_q[7], tog_q, pd_q[5:0]};
        dq_o = (!ce_n_i && !oe_n_i && we_n_i) ? rv : ~last_q;
    end
    always @(negedge oe_n_i) if (busy_q) tog_q = ~tog_q;
    always @(posedge oe_n_i) last_q = rv;
    always @(negedge we_n_i or negedge ce_n_i)
    begin
        act_q = !we_n_i && !ce_n_i && oe_n_i;
        a_q   = addr_i;
        t0    = $realtime;
    end
    always @(posedge we_n_i or posedge ce_n_i)
    begin
        if (act_q && !busy_q && $realtime - t0 >= 15.0) cmd(a_q, dq_i);
        act_q = 1'b0;
    end
    task automatic cmd(input logic [15:0] a, input logic [15:0] d);
        logic at5;
        at5 = a[11:0] == 12'h555;
        if (step_q == 3)
        begin
            if (!(lock_q && a < 16'h2000)) mem_q[int'(a)] = (mem_q.exists(int'(a)) ? mem_q[int'(a)] : 16'hFFFF) & d;
            pd_q   = d;
            busy_q = 1'b1;
            busy_q <= #(PROG_NS) 1'b0;
        end
        if (d[7:0] == 8'hF0 && (step_q == 0 || step_q == 2 && at5)) id_q = 1'b0;
        if (step_q == 2 && at5 && d[7:0] == 8'h90) id_q = 1'b1;
        if (step_q == 6 && at5 && d[7:0] == 8'h40) lock_q = 1'b1;
        if (step_q == 6 && at5 && (d[7:0] == 8'h10 || d[7:0] == 8'h30))
        begin
            foreach (mem_q[k])
                if (k >= 'h2000 || !(lock_q || d[7:0] == 8'h30)) mem_q[k] = 16'hFFFF;
            pd_q   = 16'hFFFF;
            busy_q = 1'b1;
            busy_q <= #(ERASE_NS) 1'b0;
        end
        case (step_q)
            0, 4: step_q = (at5 && d[7:0] == 8'hAA) ? step_q + 1 : 0;
            1, 5: step_q = (a[11:0] == 12'hAAA && d[7:0] == 8'h55) ? step_q + 1 : 0;
            2: step_q = !at5 ? 0 : (d[7:0] == 8'hA0) ? 3 : (d[7:0] == 8'h80) ? 4 : 0;
            default: step_q = 0;
        endcase
    endtask
endmodule // flash_dev_model

// ===== verif/test_flash_ctrl.sv
// self-checking bench for the flash controller
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module test_flash_ctrl;
    logic        clk_i = 1'b0, arst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0, v, rdata_o, fl_addr_o, fl_dq_o, dev_dq, dq_wire;
    logic        fl_dq_oe_o, fl_ce_n_o, fl_oe_n_o, fl_we_n_o;
    int          errors = 0, compares = 0;
    assign dq_wire = fl_dq_oe_o ? fl_dq_o : dev_dq;
    always #20 clk_i = ~clk_i;
    flash_ctrl dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .fl_addr_o(fl_addr_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o),
        .fl_dq_i(dq_wire), .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o));
    flash_dev_model mdl (.addr_i(fl_addr_o), .dq_i(dq_wire), .ce_n_i(fl_ce_n_o), .oe_n_i(fl_oe_n_o),
        .we_n_i(fl_we_n_o), .dq_o(dev_dq));
    task automatic tally_and_finish();
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
        @(posedge clk_i);
    endtask
    task automatic op(input logic [3:0] c, input logic [15:0] a, input logic [15:0] d);
        int n;
        n = 0;
        wr(`REG_ADDR, a);
        wr(`REG_WDATA, d);
        wr(`REG_CMD, {12'h0, c});
        do
        begin
            rd(`REG_STATUS);
            n++;
        end while (v[1:0] !== 2'b10 && n < 20000);
        chk({13'h0, v[2:0]}, 16'h0002);
    endtask
    task automatic rchk(input logic [15:0] a, input logic [15:0] e);
        op(4'h1, a, 16'h0);
        rd(`REG_RDATA);
        chk(v, e);
    endtask
    task automatic lockq(input logic [15:0] e, input logic [3:0] ex);
        op(4'h6, 16'h0, 16'h0);
        op(4'h9, `ADDR_LOCKQ, 16'h0);
        rd(`REG_RDATA);
        chk({15'h0, v[0]}, e);
        op(ex, 16'h0, 16'h0);
        rchk(`ADDR_LOCKQ, 16'hFFFF);
    endtask
    initial
    begin
        repeat (16) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        chk({14'h0, fl_ce_n_o, fl_we_n_o}, 16'h0003);
        rchk(16'h3000, 16'hFFFF);
        rd(`REG_ADDR);
        chk(v, 16'h3000);
        op(4'h2, 16'h3000, 16'h1234);
        rchk(16'h3000, 16'h1234);
        op(4'h2, 16'h3000, 16'h0F0F);
        rchk(16'h3000, 16'h0204);
        op(4'h2, 16'h0100, 16'h5678);
        op(4'h3, 16'h0, 16'h0);
        rd(`REG_POLLS);
        chk({15'h0, v != 16'h0000}, 16'h0001);
        rchk(16'h0100, 16'hFFFF);
        op(4'h2, 16'h0100, 16'h5678);
        op(4'h2, 16'h2000, 16'h0F0F);
        lockq(16'h0000, 4'h7);
        op(4'h5, 16'h0, 16'h0);
        lockq(16'h0001, 4'h8);
        op(4'h2, 16'h0100, 16'h0000);
        rchk(16'h0100, 16'h5678);
        op(4'h4, 16'h0, 16'h0);
        rchk(16'h2000, 16'hFFFF);
        rchk(16'h0100, 16'h5678);
        op(4'h2, 16'h3000, 16'h0F0F);
        op(4'h3, 16'h0, 16'h0);
        rchk(16'h3000, 16'hFFFF);
        rchk(16'h0100, 16'h5678);
        tally_and_finish();
    end
    initial
    begin
        #3000000;
        errors++;
        tally_and_finish();
    end
endmodule // test_flash_ctrl
bind flash_ctrl flash_ctrl_chk u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fl_addr_o(fl_addr_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o),
    .fl_dq_i(fl_dq_i), .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o));
